// [rtl/charger_defines.vh]
// Constants for the charger SMBus register port.
// Summary of operation
// - Input over limit throttles the charge current down toward zero, system load first.
// - Input current limit register is 16 bits, 20uV or 2mA per count.
// - Input current limit sits at command 0x3F, write-word, reads back stored word.
// - Low 7 bits ignored, bits 12..7 drive the DAC, any of bits 15..13 set saturates the DAC.
// - Requests above 11.008A saturate the DAC code instead of wrapping.
// - Requests from zero up to 254mA give an effective setting of zero.
// - After reset the input current limit is 256mA, the lowest nonzero step.
// - Charging stops without a voltage or current setpoint write for 175s.
// - Charging stops when the clock line stays low longer than 25ms.
// - After a timeout charging stays off until voltage or current is rewritten.
// - Registers are 16 bits moved as two bytes, low byte first.
// - Write: address with write bit, command, low, high, Stop; each byte acknowledged.
// - A written setting takes effect only at the closing Stop.
// - One register per write transaction; extra bytes are not accepted.
// - Read: device acks address, sends low byte, host acks, high byte, host nacks.
// - One register per read transaction; no further data is supplied.
// - Five registers are readable through the previously selected command byte.
// - Voltage setpoint sits at command 0x15, write-word, same byte order.
// - Voltage and current setpoints reset to zero; charger off until both are set.
`ifndef CHARGER_DEFINES_VH
`define CHARGER_DEFINES_VH

`define SLAVE_ADDR        7'h09
`define CMD_VOLTAGE       8'h15
`define CMD_CURRENT       8'h14
`define CMD_INPUT_LIMIT   8'h3F
`define CMD_MFR_ID        8'hFE
`define CMD_DEV_ID        8'hFF

`define VOLTAGE_RESET     16'h0000
`define CURRENT_RESET     16'h0000
`define INPUT_LIMIT_RESET 16'h0080
`define INPUT_DAC_RESET   6'h01

`define DAC_LSB           7
`define DAC_MSB           12
`define INPUT_DAC_MAX     6'h2B
`define CURRENT_DAC_MAX   6'h3F

// Clock is 100 MHz; write watchdog is 175 s, clock-low watchdog is 25 ms.
`define CLK_HZ            64'h5F5E100
`define WRITE_TIMEOUT_S   64'hAF
`define SCL_LOW_MS        64'h19
`define MS_PER_S          64'h3E8
`define THROTTLE_STEP     16'h0100

`endif

// [rtl/charger_smbus_register_port.v]
// SMBus slave register port of the charger with setpoints, input limit DAC and watchdogs.
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.vh"
module charger_smbus_register_port #(
  parameter [6:0]  SLAVE_ADDR             = `SLAVE_ADDR,
  // Identification values are arbitrary.
  parameter [15:0] MFR_ID                 = 16'h00A5,
  parameter [15:0] DEV_ID                 = 16'h005A,
  parameter [63:0] WRITE_TIMEOUT_CYCLES   = `WRITE_TIMEOUT_S * `CLK_HZ,
  parameter [63:0] SCL_LOW_TIMEOUT_CYCLES = (`SCL_LOW_MS * `CLK_HZ) / `MS_PER_S,
  parameter [15:0] THROTTLE_STEP_CYCLES   = `THROTTLE_STEP
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        scl,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        input_over_limit,
  output reg         charge_enable,
  output reg  [15:0] battery_voltage_setpoint,
  output reg  [15:0] battery_current_setpoint,
  output reg  [15:0] input_current_limit,
  output reg  [5:0]  input_limit_dac_bits,
  output reg  [5:0]  charge_current_dac_bits,
  output reg         write_timeout,
  output reg         scl_low_timeout
);
  // Receive states shift eight bits and hand over to ST_ACK (ST_ADDR only on its own address), which pulls the line for the ninth bit and
  // then moves to ret_state. ST_TX and ST_MACK send a read word one byte at a time, each byte followed by
  // the host's own acknowledge bit.
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_ADDR  = 4'h1;
  localparam [3:0] ST_CMD   = 4'h2;
  localparam [3:0] ST_DLO   = 4'h3;
  localparam [3:0] ST_DHI   = 4'h4;
  localparam [3:0] ST_ACK   = 4'h5;
  localparam [3:0] ST_TX    = 4'h6;
  localparam [3:0] ST_MACK  = 4'h7;
  localparam [3:0] ST_WAIT  = 4'h8;

  wire [1:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  reg        scl_q;
  reg        sda_q;
  reg        over_meta;
  reg        over_s;

  smbus_pin_sync #(
    .W      (2)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({scl, sda_in}),
    .q      (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always @(posedge clk) begin
    if (!resetn) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      over_meta <= 1'b0;
      over_s    <= 1'b0;
    end else begin
      scl_q     <= scl_s;
      sda_q     <= sda_s;
      over_meta <= input_over_limit;
      over_s    <= over_meta;
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start    = scl_s & scl_q & sda_q & ~sda_s;
  wire stop     = scl_s & scl_q & ~sda_q & sda_s;

  reg [3:0]  state;
  reg [3:0]  ret_state;
  reg [3:0]  bit_cnt;
  reg [7:0]  shreg;
  reg [7:0]  tx_sh;
  reg [7:0]  cmd;
  reg [7:0]  data_lo;
  reg [7:0]  data_hi;
  reg        wr_done;
  reg        hi_sent;
  reg        ack_seen;
  reg [15:0] read_word;

  // The command byte of the last write selects what a read returns.
  always @* begin
    case (cmd)
      `CMD_VOLTAGE:     read_word = battery_voltage_setpoint;
      `CMD_CURRENT:     read_word = battery_current_setpoint;
      `CMD_INPUT_LIMIT: read_word = input_current_limit;
      `CMD_MFR_ID:      read_word = MFR_ID;
      `CMD_DEV_ID:      read_word = DEV_ID;
      default:          read_word = 16'h0000;
    endcase
  end

  // Bits are taken on the clock's rising edge; the data line only changes after a falling edge.
  always @(posedge clk) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      ret_state <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      tx_sh     <= 8'h00;
      cmd       <= 8'h00;
      data_lo   <= 8'h00;
      data_hi   <= 8'h00;
      wr_done   <= 1'b0;
      hi_sent   <= 1'b0;
      ack_seen  <= 1'b0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
    end else if (start) begin
      // A repeated start drops an unfinished write; only a Stop commits.
      state   <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
      wr_done <= 1'b0;
    end else if (stop) begin
      state   <= ST_IDLE;
      sda_oe  <= 1'b0;
      wr_done <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_DLO, ST_DHI: begin
          if (scl_rise && bit_cnt != 4'h8) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            case (state)
              ST_ADDR: begin
                if (shreg[7:1] == SLAVE_ADDR) begin
                  sda_oe    <= 1'b1;
                  state     <= ST_ACK;
                  ret_state <= shreg[0] ? ST_TX : ST_CMD;
                end else begin
                  state <= ST_WAIT;
                end
              end
              ST_CMD: begin
                cmd       <= shreg;
                sda_oe    <= 1'b1;
                state     <= ST_ACK;
                ret_state <= ST_DLO;
              end
              ST_DLO: begin
                data_lo   <= shreg;
                sda_oe    <= 1'b1;
                state     <= ST_ACK;
                ret_state <= ST_DHI;
              end
              ST_DHI: begin
                data_hi   <= shreg;
                wr_done   <= 1'b1;
                sda_oe    <= 1'b1;
                state     <= ST_ACK;
                ret_state <= ST_WAIT;
              end
              default: begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state   <= ret_state;
            bit_cnt <= 4'h0;
            if (ret_state == ST_TX) begin
              sda_oe  <= ~read_word[7];
              tx_sh   <= {read_word[6:0], 1'b0};
              hi_sent <= 1'b0;
            end else begin
              sda_oe <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise)
            bit_cnt <= bit_cnt + 4'h1;
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe  <= 1'b0;
              state   <= ST_MACK;
              bit_cnt <= 4'h0;
            end else begin
              sda_oe <= ~tx_sh[7];
              tx_sh  <= {tx_sh[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise)
            ack_seen <= ~sda_s;
          if (scl_fall) begin
            if (ack_seen && !hi_sent) begin
              sda_oe  <= ~read_word[15];
              tx_sh   <= {read_word[14:8], 1'b0};
              hi_sent <= 1'b1;
              state   <= ST_TX;
            end else begin
              // A host that acknowledges the high byte anyway sees a released line from here on.
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // Extra bytes go unacknowledged until the host ends the transaction.
          sda_oe <= 1'b0;
        end
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  wire        commit   = stop & wr_done;
  wire [15:0] wr_word  = {data_hi, data_lo};
  wire        feed     = commit & ((cmd == `CMD_VOLTAGE) | (cmd == `CMD_CURRENT));
  wire [5:0]  in_code  = wr_word[`DAC_MSB:`DAC_LSB];
  wire        in_over  = (wr_word[15:13] != 3'h0) | (in_code > `INPUT_DAC_MAX);
  wire        setpoints_valid = (battery_voltage_setpoint != 16'h0000) & (battery_current_setpoint != 16'h0000);
  reg  [5:0]  in_dac;
  reg  [5:0]  cur_code;

  // Input limit code: a request past the top step saturates, one below 256mA is naturally zero.
  always @* begin
    if (in_over)
      in_dac = `INPUT_DAC_MAX;
    else
      in_dac = in_code;
  end

  // Charge current code: any of bits 15..13 set asks for more than the top step.
  always @* begin
    if (battery_current_setpoint[15:13] != 3'h0)
      cur_code = `CURRENT_DAC_MAX;
    else
      cur_code = battery_current_setpoint[`DAC_MSB:`DAC_LSB];
  end

  always @(posedge clk) begin
    if (!resetn) begin
      battery_voltage_setpoint <= `VOLTAGE_RESET;
      battery_current_setpoint <= `CURRENT_RESET;
      input_current_limit      <= `INPUT_LIMIT_RESET;
      input_limit_dac_bits     <= `INPUT_DAC_RESET;
    end else if (commit) begin
      case (cmd)
        `CMD_VOLTAGE: battery_voltage_setpoint <= wr_word;
        `CMD_CURRENT: battery_current_setpoint <= wr_word;
        `CMD_INPUT_LIMIT: begin
          input_current_limit <= wr_word;
          input_limit_dac_bits <= in_dac;
        end
        default: input_current_limit <= input_current_limit;
      endcase
    end
  end

  reg [35:0] wr_cnt;
  reg [35:0] low_cnt;
  wire       wr_expired  = ({28'h0, wr_cnt} >= WRITE_TIMEOUT_CYCLES);
  wire       low_expired = ({28'h0, low_cnt} > SCL_LOW_TIMEOUT_CYCLES);

  // Both counters park once expired, so each flag is set only on the way in; a level set would hold the
  // flag through the very setpoint write meant to clear it. An expiry landing with such a write still wins.
  always @(posedge clk) begin
    if (!resetn) begin
      wr_cnt        <= 36'h0;
      write_timeout <= 1'b0;
    end else begin
      if (feed)
        wr_cnt <= 36'h0;
      else if (!wr_expired)
        wr_cnt <= wr_cnt + 36'h1;
      if (wr_expired && !write_timeout)
        write_timeout <= 1'b1;
      else if (feed)
        write_timeout <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      low_cnt         <= 36'h0;
      scl_low_timeout <= 1'b0;
    end else begin
      if (scl_s)
        low_cnt <= 36'h0;
      else if (!low_expired)
        low_cnt <= low_cnt + 36'h1;
      if (low_expired && !scl_low_timeout)
        scl_low_timeout <= 1'b1;
      else if (feed)
        scl_low_timeout <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!resetn)
      charge_enable <= 1'b0;
    else
      charge_enable <= setpoints_valid & ~write_timeout & ~scl_low_timeout;
  end

  // The loop steps the current code by one each interval, dropping at once to a lower target, a coarse digital stand-in for the
  // analog regulator: slow enough not to chatter, but it lags fast load transients.
  reg [15:0] step_cnt;
  wire       step = (step_cnt == 16'h0000);
  wire [5:0] target = charge_enable ? cur_code : 6'h00;

  always @(posedge clk) begin
    if (!resetn) begin
      step_cnt                <= 16'h0000;
      charge_current_dac_bits <= 6'h00;
    end else begin
      step_cnt <= step ? THROTTLE_STEP_CYCLES - 16'h1 : step_cnt - 16'h1;
      if (charge_current_dac_bits > target)
        charge_current_dac_bits <= target;
      else if (step && over_s && charge_current_dac_bits != 6'h00)
        charge_current_dac_bits <= charge_current_dac_bits - 6'h01;
      else if (step && !over_s && charge_current_dac_bits < target)
        charge_current_dac_bits <= charge_current_dac_bits + 6'h01;
    end
  end
endmodule
`default_nettype wire

// [rtl/smbus_pin_sync.v]
// Two-flop synchroniser for the bus pins.
`timescale 1ns/1ps
`default_nettype none
module smbus_pin_sync #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  // An idle bus reads high, so both stages reset to ones.
  always @(posedge clk) begin
    if (!resetn) begin
      meta <= {W{1'b1}};
      q    <= {W{1'b1}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// [tb/charger_port_monitor.sv]
// Assertion checker bound to the charger SMBus register port.
`timescale 1ns/1ps
`default_nettype none
module charger_port_monitor #(
  parameter [63:0] WRITE_TIMEOUT_CYCLES   = 64'h0,
  parameter [63:0] SCL_LOW_TIMEOUT_CYCLES = 64'h0
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        scl,
  input wire logic        input_over_limit,
  input wire logic        charge_enable,
  input wire logic [15:0] battery_voltage_setpoint,
  input wire logic [15:0] battery_current_setpoint,
  input wire logic [15:0] input_current_limit,
  input wire logic [5:0]  input_limit_dac_bits,
  input wire logic [5:0]  charge_current_dac_bits,
  input wire logic        write_timeout,
  input wire logic        scl_low_timeout
);
  localparam integer WR_T  = WRITE_TIMEOUT_CYCLES[31:0];
  localparam integer LOW_T = SCL_LOW_TIMEOUT_CYCLES[31:0];
  integer low_cnt;
  integer wr_cnt;
  function automatic [5:0] dac_of(input [15:0] v);
    dac_of = (v[15:13] != 3'h0 || v[12:7] > 6'h2B) ? 6'h2B : v[12:7];
  endfunction
  // The clock-low counter watches the pin, so its bounds leave room for the synchroniser delay.
  always @(posedge clk) begin
    low_cnt <= (!resetn || scl) ? 0 : low_cnt + 1;
    if (!resetn || $changed(battery_voltage_setpoint) || $changed(battery_current_setpoint))
      wr_cnt <= 0;
    else
      wr_cnt <= wr_cnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  reset_values_a: assert property ($rose(resetn) |-> input_current_limit == 16'h0080
    && input_limit_dac_bits == 6'h01 && battery_voltage_setpoint == 16'h0000 && !charge_enable)
    else $error("reset values wrong");
  dac_map_a: assert property ($stable(input_current_limit) |->
    input_limit_dac_bits == dac_of(input_current_limit)) else $error("input dac wrong");
  enable_gate_a: assert property (charge_enable |-> $past(battery_voltage_setpoint) != 16'h0000
    && $past(battery_current_setpoint) != 16'h0000 && !$past(write_timeout) && !$past(scl_low_timeout))
    else $error("charger enabled wrongly");
  wr_late_a: assert property ($rose(write_timeout) |-> wr_cnt >= WR_T - 2)
    else $error("write watchdog early");
  low_late_a: assert property ($rose(scl_low_timeout) |-> low_cnt >= LOW_T && low_cnt <= LOW_T + 8)
    else $error("clock-low watchdog mistimed");
  low_due_a: assert property (low_cnt == LOW_T + 10 |-> scl_low_timeout)
    else $error("clock-low watchdog missed");
  cur_step_a: assert property (charge_current_dac_bits > $past(charge_current_dac_bits) |->
    charge_current_dac_bits == $past(charge_current_dac_bits) + 6'h01) else $error("charge dac jumped");
  over_hold_a: assert property (input_over_limit [*6] |->
    charge_current_dac_bits <= $past(charge_current_dac_bits)) else $error("charge dac rose over limit");
endmodule
bind charger_smbus_register_port charger_port_monitor #(
  .WRITE_TIMEOUT_CYCLES(WRITE_TIMEOUT_CYCLES), .SCL_LOW_TIMEOUT_CYCLES(SCL_LOW_TIMEOUT_CYCLES)
) u_charger_port_monitor (
  .clk(clk), .resetn(resetn), .scl(scl), .input_over_limit(input_over_limit), .charge_enable(charge_enable),
  .battery_voltage_setpoint(battery_voltage_setpoint), .battery_current_setpoint(battery_current_setpoint),
  .input_current_limit(input_current_limit), .input_limit_dac_bits(input_limit_dac_bits),
  .charge_current_dac_bits(charge_current_dac_bits), .write_timeout(write_timeout),
  .scl_low_timeout(scl_low_timeout));
`default_nettype wire

// [tb/smbus_host_model.sv]
// Behavioural SMBus host mastering the bus on the far side of the register port.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input  wire logic clk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output var  logic scl,
  output wire logic sda
);
  logic hold = 1'b0;
  // The line has a pull-up, so a released bus reads high.
  assign sda = ~(hold | (sda_oe & ~sda_out));
  initial scl = 1'b1;
  task automatic w(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data moves mid-way through the low phase so it never races the clock edge.
  task automatic bit_io(input logic b, output logic r);
    w(2);
    hold = ~b;
    w(2);
    scl = 1'b1;
    w(4);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    hold = 1'b1;
    w(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    w(2);
    hold = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    hold = 1'b0;
    w(4);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  task automatic hold_low(input integer n);
    scl = 1'b0;
    w(n);
    scl = 1'b1;
    w(4);
  endtask
endmodule
`default_nettype wire

// [tb/tb_charger_smbus_register_port.sv]
// Self-checking bench for the charger SMBus register port.
`timescale 1ns/1ps
`default_nettype none
module tb_charger_smbus_register_port;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        over = 1'b0;
  logic [15:0] obs = 16'h0000;
  logic        obs_v = 1'b0;
  logic [15:0] exp_q [$];
  logic [15:0] regs [0:255];
  logic [31:0] x = 32'h0A16;
  integer      checks = 0;
  integer      failures = 0;
  wire         scl, sda, sda_out, sda_oe, en, wto, lto;
  wire  [15:0] vset, iset, ilim;
  wire  [5:0]  dac, cdac;
  always #5 clk = ~clk;
  charger_smbus_register_port #(
    .WRITE_TIMEOUT_CYCLES(64'hBB8), .SCL_LOW_TIMEOUT_CYCLES(64'h1F4), .THROTTLE_STEP_CYCLES(16'h0004)
  ) u_charger_smbus_register_port (
    .clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .input_over_limit(over), .charge_enable(en), .battery_voltage_setpoint(vset),
    .battery_current_setpoint(iset), .input_current_limit(ilim), .input_limit_dac_bits(dac),
    .charge_current_dac_bits(cdac), .write_timeout(wto), .scl_low_timeout(lto));
  smbus_host_model u_smbus_host_model (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
  always @(posedge clk) begin
    if (obs_v) begin
      checks = checks + 1;
      if (exp_q.size() == 0 || obs !== exp_q[0]) begin
        failures = failures + 1;
        $display("BAD %0t got %h", $time, obs);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  task automatic wt(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xorshift = t ^ (t << 5);
  endfunction
  task automatic chk(input logic [15:0] e, input logic [15:0] v);
    exp_q.push_back(e);
    obs = v;
    obs_v = 1'b1;
    wt(1);
    obs_v = 1'b0;
    wt(1);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [3:0] a;
    u_smbus_host_model.start();
    u_smbus_host_model.put(8'h12, a[3]);
    u_smbus_host_model.put(c, a[2]);
    u_smbus_host_model.put(d[7:0], a[1]);
    u_smbus_host_model.put(d[15:8], a[0]);
    chk(regs[8'h3F], ilim);
    u_smbus_host_model.stop();
    if (c == 8'h14 || c == 8'h15 || c == 8'h3F) regs[c] = d;
    chk(16'h000F, {12'h000, a});
    wt(2);
    chk(regs[8'h3F], ilim);
    chk((regs[8'h3F][15:13] != 3'h0 || regs[8'h3F][12:7] > 6'h2B) ? 16'h002B : 16'(regs[8'h3F][12:7]),
        16'(dac));
  endtask
  task automatic rd(input logic [7:0] c);
    logic [7:0] lo;
    logic [7:0] hi;
    logic       a;
    u_smbus_host_model.start();
    u_smbus_host_model.put(8'h12, a);
    u_smbus_host_model.put(c, a);
    u_smbus_host_model.stop();
    u_smbus_host_model.start();
    u_smbus_host_model.put(8'h13, a);
    u_smbus_host_model.get(1'b0, lo);
    u_smbus_host_model.get(1'b1, hi);
    u_smbus_host_model.stop();
    chk(regs[c], {hi, lo});
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Bounded well above the expected length of the sequence below.
  initial begin
    #400000;
    failures = failures + 1;
    results();
  end
  initial begin
    logic [15:0] tbl [10];
    logic [7:0]  cmds [6];
    logic        a;
    logic [7:0]  rb;
    tbl = '{16'h41A0, 16'h0000, 16'h007F, 16'h0080, 16'h15FF, 16'h1600, 16'h2000, 16'h0, 16'h0, 16'h0};
    cmds = '{8'h14, 8'h15, 8'h3F, 8'hFE, 8'hFF, 8'h20};
    foreach (regs[i]) regs[i] = 16'h0000;
    regs[8'h3F] = 16'h0080;
    // Identification words follow the design defaults, which are arbitrary.
    regs[8'hFE] = 16'h00A5;
    regs[8'hFF] = 16'h005A;
    wt(4);
    resetn = 1'b1;
    wt(3);
    chk(16'h0080, ilim);
    chk(16'h0001, 16'(dac));
    chk(16'h0000, vset | iset | 16'(en));
    chk(16'h0000, {14'h0000, sda_out, sda_oe});
    rd(8'h3F);
    for (int i = 0; i < 10; i++) begin
      x = xorshift(x);
      wr(8'h3F, (i < 7) ? tbl[i] : x[15:0]);
      rd(8'h3F);
    end
    u_smbus_host_model.start();
    u_smbus_host_model.put(8'h14, a);
    u_smbus_host_model.stop();
    chk(16'h0000, 16'(a));
    // A fifth byte is refused; the word before it still commits at the Stop.
    u_smbus_host_model.start();
    u_smbus_host_model.put(8'h12, a);
    u_smbus_host_model.put(8'h3F, a);
    u_smbus_host_model.put(8'h00, a);
    u_smbus_host_model.put(8'h05, a);
    u_smbus_host_model.put(8'h01, a);
    chk(16'h0000, 16'(a));
    u_smbus_host_model.stop();
    regs[8'h3F] = 16'h0500;
    rd(8'h3F);
    // A third read byte finds the line released.
    u_smbus_host_model.start();
    u_smbus_host_model.put(8'h13, a);
    u_smbus_host_model.get(1'b0, rb);
    u_smbus_host_model.get(1'b0, rb);
    u_smbus_host_model.get(1'b1, rb);
    u_smbus_host_model.stop();
    chk(16'h00FF, 16'(rb));
    wr(8'h15, 16'h3000);
    chk(16'h0000, 16'(en));
    wr(8'h14, 16'h0F80);
    wt(200);
    chk(16'h0001, 16'(en));
    chk(16'h001F, 16'(cdac));
    over = 1'b1;
    wt(200);
    chk(16'h0000, 16'(cdac));
    over = 1'b0;
    wt(200);
    chk(16'h001F, 16'(cdac));
    wt(3000);
    chk(16'h0002, {14'h0000, wto, en});
    wr(8'h14, 16'h0F80);
    chk(16'h0001, {14'h0000, wto, en});
    u_smbus_host_model.hold_low(600);
    chk(16'h0002, {14'h0000, lto, en});
    wr(8'h3F, 16'h0080);
    chk(16'h0002, {14'h0000, lto, en});
    wr(8'h15, 16'h3000);
    chk(16'h0001, {14'h0000, lto, en});
    wr(8'hFE, 16'h1234);
    foreach (cmds[i]) rd(cmds[i]);
    results();
  end
endmodule
`default_nettype wire
